// file: clksw_pkg.sv
package clksw_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
	localparam logic [3:0] CFG_OFS      = 4'h4;

	// osc_control_reg field positions
	localparam int CUR_SRC_LSB = 12;
	localparam int NEW_SRC_LSB = 8;
	localparam int LOCK_BIT    = 5;
	localparam int FAIL_BIT    = 3;
	localparam int SEC_EN_BIT  = 1;
	localparam int REQ_BIT     = 0;

	// config_word_two field positions
	localparam int CFG_MON_LSB      = 0;
	localparam int CFG_INIT_SRC_LSB = 2;
	localparam int CFG_PRESCALE_LSB = 5;
	localparam int CFG_SYSDIV_LSB   = 8;
	localparam int CFG_USB_EN_BIT   = 10;
	localparam int CFG_WDOG_EN_BIT  = 11;
	localparam int CFG_PRI_XT_BIT  = 12;

	// reset values
	localparam logic [15:0] CFG_RESET     = 16'h1003;
	localparam logic [2:0]  NEW_SRC_RESET = 3'h0;

	// unlock keys
	localparam logic [7:0] KEY_HI_1 = 8'h78;
	localparam logic [7:0] KEY_HI_2 = 8'h9a;
	localparam logic [7:0] KEY_LO_1 = 8'h46;
	localparam logic [7:0] KEY_LO_2 = 8'h57;

	// source select codes
	localparam logic [2:0] SRC_FAST_RC     = 3'h0;
	localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI         = 3'h2;
	localparam logic [2:0] SRC_PRI_PLL     = 3'h3;
	localparam logic [2:0] SRC_SEC         = 3'h4;
	localparam logic [2:0] SRC_SLOW_RC     = 3'h5;

	// oscillator indices
	localparam logic [1:0] OSC_FAST_RC = 2'h0;
	localparam logic [1:0] OSC_PRI     = 2'h1;
	localparam logic [1:0] OSC_SEC     = 2'h2;
	localparam logic [1:0] OSC_SLOW_RC = 2'h3;

	// timing and divider constants
	localparam logic [3:0] NEW_SRC_WAIT    = 4'ha;
	localparam logic [1:0] USB_DIV         = 2'h2;
	localparam logic [4:0] SYS_BRANCH_BASE = 5'h03;

	typedef enum logic [2:0] {
		ULK_IDLE = 3'b001,
		ULK_KEY1 = 3'b010,
		ULK_OPEN = 3'b100
	} ulk_t;

	typedef enum logic [4:0] {
		SW_IDLE    = 5'b00001,
		SW_COMPARE = 5'b00010,
		SW_START   = 5'b00100,
		SW_COUNT   = 5'b01000,
		SW_SWAP    = 5'b10000
	} sw_state_t;

	// oscillator that feeds a source code
	function automatic logic [1:0] src_osc(input logic [2:0] src);
		case (src)
			SRC_PRI, SRC_PRI_PLL: src_osc = OSC_PRI;
			SRC_SEC:              src_osc = OSC_SEC;
			SRC_SLOW_RC:          src_osc = OSC_SLOW_RC;
			default:              src_osc = OSC_FAST_RC;
		endcase
	endfunction : src_osc

	function automatic logic src_pll(input logic [2:0] src);
		src_pll = (src == SRC_FAST_RC_PLL) || (src == SRC_PRI_PLL);
	endfunction : src_pll

	// prescaler ratio from the three-bit code
	function automatic logic [3:0] prescale_div(input logic [2:0] code);
		case (code)
			3'h6:    prescale_div = 4'h8;
			3'h7:    prescale_div = 4'hc;
			default: prescale_div = 4'(code) + 4'h1;
		endcase
	endfunction : prescale_div

endpackage : clksw_pkg

// file: clock_switch_and_usb_pll.sv
// Functional notes
// - switching and fail-safe monitor allowed only when monitor config equals 00
// - switching disabled: new-source ignored, current source shows initial config
// - switching disabled: switch request has no effect and reads zero
// - equal current and new sources abort the switch and clear the request
// - valid switch start clears lock status and clock-fail flag
// - start new oscillator; wait start-up timer for crystal, lock for PLL
// - wait ten cycles of the new source before swapping
// - on success clear request and copy new source into current source
// - old source off, except low-power RC or secondary when still needed
// - processor keeps running; bus never stalls during a switch
// - no direct switch between primary PLL and fast RC PLL modes
// - PLL kept running for the 48 MHz USB clock while USB enabled
// - prescaler to 4 MHz, 96 MHz multiplier, USB branch /2, system /3
// - system divider 00..11 gives 32, 16, 8, 4 MHz
// - prescaler codes 000-101 divide 1-6, 110 by 8, 111 by 12
// - four selectable oscillators: primary, secondary, fast RC, low-power RC
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module clock_switch_and_usb_pll (
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RESETN,
	// avalon-mm slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// oscillator status pins
	input  wire logic [3:0]  OSC_CLK_IN,
	input  wire logic        STARTUP_DONE,
	input  wire logic        PLL_LOCKED,
	input  wire logic        CLK_FAIL,
	// clock control outputs
	output logic      [3:0]  OSC_ENABLE,
	output logic             PLL_ENABLE,
	output logic      [2:0]  SYS_CLK_SRC,
	output logic             SWITCH_BUSY,
	output logic      [3:0]  PLL_PRESCALE_DIV,
	output logic      [4:0]  SYS_BRANCH_DIV,
	output logic      [1:0]  USB_BRANCH_DIV
);
	import clksw_pkg::*;

	logic        rst_meta_q;
	logic        rst_n;
	logic [2:0]  pin_meta_q;
	logic [2:0]  pin_sync_q;
	logic        ost_s;
	logic        lock_s;
	logic        fail_s;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [15:0] rd_osc;
	logic        wr_osc;
	logic        wr_cfg;
	logic        wr_hi;
	logic        wr_lo;
	logic [15:0] cfg_q;
	ulk_t        ulk_hi_q;
	ulk_t        ulk_lo_q;
	logic [2:0]  new_src_q;
	logic [2:0]  cur_src_q;
	logic [2:0]  cur_eff;
	logic        req_q;
	logic        lock_q;
	logic        fail_q;
	logic        sec_en_q;
	sw_state_t   state_q;
	sw_state_t   state_d;
	logic        sw_en;
	logic        usb_en;
	logic        wdog_en;
	logic        bad_pair;
	logic        src_ready;
	logic        cnt_start;
	logic        cnt_done;
	logic        start_clr;
	logic [3:0]  osc_en_d;

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// pin synchronisers
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end else begin
			pin_meta_q <= {CLK_FAIL, PLL_LOCKED, STARTUP_DONE};
			pin_sync_q <= pin_meta_q;
		end
	end
	assign ost_s  = pin_sync_q[0];
	assign lock_s = pin_sync_q[1];
	assign fail_s = pin_sync_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait state, answer never held off by a switch
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
		end
	end
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;

	assign wr_osc = AVS_WRITE & ack_q & (AVS_ADDRESS == OSC_CTRL_OFS);
	assign wr_cfg = AVS_WRITE & ack_q & (AVS_ADDRESS == CFG_OFS);
	assign wr_hi  = wr_osc & AVS_BYTEENABLE[1];
	assign wr_lo  = wr_osc & AVS_BYTEENABLE[0];

	// register read image
	always_comb begin
		rd_osc = 16'h0000;
		rd_osc[CUR_SRC_LSB +: 3] = cur_eff;
		rd_osc[NEW_SRC_LSB +: 3] = new_src_q;
		rd_osc[LOCK_BIT]         = lock_q;
		rd_osc[FAIL_BIT]         = fail_q;
		rd_osc[SEC_EN_BIT]       = sec_en_q;
		rd_osc[REQ_BIT]          = req_q & sw_en;
	end

	// read data captured in the wait cycle; unmapped reads give zero
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (AVS_READ && !ack_q) begin
			case (AVS_ADDRESS)
				OSC_CTRL_OFS: rdata_q <= {16'h0000, rd_osc};
				CFG_OFS:      rdata_q <= {16'h0000, cfg_q};
				default:      rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign AVS_READDATA = rdata_q;

	// configuration word, byte-wise writable
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= CFG_RESET;
		end else if (wr_cfg) begin
			if (AVS_BYTEENABLE[0]) cfg_q[7:0]  <= AVS_WRITEDATA[7:0];
			if (AVS_BYTEENABLE[1]) cfg_q[15:8] <= AVS_WRITEDATA[15:8];
		end
	end
	assign sw_en   = (cfg_q[CFG_MON_LSB +: 2] == 2'b00);
	assign usb_en  = cfg_q[CFG_USB_EN_BIT];
	assign wdog_en = cfg_q[CFG_WDOG_EN_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// unlock detectors, one per control byte
	function automatic ulk_t ulk_next(input ulk_t st, input logic [7:0] d,
			input logic [7:0] k1, input logic [7:0] k2);
		case (st)
			ULK_IDLE: ulk_next = (d == k1) ? ULK_KEY1 : ULK_IDLE;
			ULK_KEY1: ulk_next = (d == k2) ? ULK_OPEN : ((d == k1) ? ULK_KEY1 : ULK_IDLE);
			default:  ulk_next = ULK_IDLE;
		endcase
	endfunction : ulk_next

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ulk_hi_q <= ULK_IDLE;
			ulk_lo_q <= ULK_IDLE;
		end else begin
			if (wr_hi) ulk_hi_q <= ulk_next(ulk_hi_q, AVS_WRITEDATA[15:8], KEY_HI_1, KEY_HI_2);
			if (wr_lo) ulk_lo_q <= ulk_next(ulk_lo_q, AVS_WRITEDATA[7:0], KEY_LO_1, KEY_LO_2);
		end
	end

	// new source written only right after the high-byte unlock
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			new_src_q <= NEW_SRC_RESET;
		end else if (wr_hi && ulk_hi_q == ULK_OPEN) begin
			new_src_q <= AVS_WRITEDATA[NEW_SRC_LSB +: 3];
		end
	end

	// secondary enable held by software
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			sec_en_q <= 1'b0;
		end else if (wr_lo && ulk_lo_q == ULK_OPEN) begin
			sec_en_q <= AVS_WRITEDATA[SEC_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// switch sequencer
	assign bad_pair  = (src_pll(new_src_q) && src_pll(cur_src_q));
	assign start_clr = (state_q == SW_COMPARE) && (new_src_q != cur_src_q) && !bad_pair;
	assign src_ready = src_pll(new_src_q) ? lock_s :
		((src_osc(new_src_q) == OSC_PRI && cfg_q[CFG_PRI_XT_BIT]) ? ost_s : 1'b1);
	assign cnt_start = (state_q == SW_START) && src_ready;

	always_comb begin
		state_d = state_q;
		case (state_q)
			SW_IDLE:    if (req_q) state_d = SW_COMPARE;
			SW_COMPARE: state_d = start_clr ? SW_START : SW_IDLE;
			SW_START:   if (src_ready) state_d = SW_COUNT;
			SW_COUNT:   if (cnt_done) state_d = SW_SWAP;
			SW_SWAP:    state_d = SW_IDLE;
			default:    state_d = SW_IDLE;
		endcase
		if (!sw_en) state_d = SW_IDLE;
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SW_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ten edges of the new source before the swap
	new_clk_counter new_clk_counter_inst (
		.clk     (CLK_SYS),
		.rst_n   (rst_n),
		.start   (cnt_start),
		.sel     (src_osc(new_src_q)),
		.osc_clk (OSC_CLK_IN),
		.done    (cnt_done)
	);

	// switch request: set by unlocked low-byte write, cleared by hardware
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= 1'b0;
		end else if (!sw_en) begin
			req_q <= 1'b0;
		end else if (wr_lo && ulk_lo_q == ULK_OPEN && AVS_WRITEDATA[REQ_BIT]) begin
			req_q <= 1'b1;
		end else if ((state_q == SW_COMPARE && !start_clr) || state_q == SW_SWAP) begin
			req_q <= 1'b0;
		end
	end

	// current source; tracks initial config while switching is off
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			cur_src_q <= NEW_SRC_RESET;
		end else if (!sw_en) begin
			cur_src_q <= cfg_q[CFG_INIT_SRC_LSB +: 3];
		end else if (state_q == SW_SWAP) begin
			cur_src_q <= new_src_q;
		end
	end
	assign cur_eff = sw_en ? cur_src_q : cfg_q[CFG_INIT_SRC_LSB +: 3];

	// lock status: set wins over the start-of-switch clear
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= lock_s | (lock_q & ~start_clr);
		end
	end

	// clock-fail flag: monitor sets, start or software write of 0 clears
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			fail_q <= 1'b0;
		end else if (fail_s && sw_en) begin
			fail_q <= 1'b1;
		end else if (start_clr || (wr_lo && ulk_lo_q == ULK_OPEN && !AVS_WRITEDATA[FAIL_BIT])) begin
			fail_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator and PLL enables
	always_comb begin
		osc_en_d = 4'h0;
		osc_en_d[src_osc(cur_eff)] = 1'b1;
		if (state_q != SW_IDLE) osc_en_d[src_osc(new_src_q)] = 1'b1;
		if (wdog_en || sw_en) osc_en_d[OSC_SLOW_RC] = 1'b1;
		if (sec_en_q) osc_en_d[OSC_SEC] = 1'b1;
		if (usb_en) osc_en_d[OSC_PRI] = 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			OSC_ENABLE  <= 4'h1;
			PLL_ENABLE  <= 1'b0;
			SYS_CLK_SRC <= NEW_SRC_RESET;
			SWITCH_BUSY <= 1'b0;
		end else begin
			OSC_ENABLE  <= osc_en_d;
			PLL_ENABLE  <= usb_en | src_pll(cur_eff) |
				(state_q != SW_IDLE && src_pll(new_src_q));
			SYS_CLK_SRC <= cur_eff;
			SWITCH_BUSY <= state_d != SW_IDLE;
		end
	end

	// USB PLL divider settings
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			PLL_PRESCALE_DIV <= 4'h1;
			SYS_BRANCH_DIV   <= SYS_BRANCH_BASE;
			USB_BRANCH_DIV   <= USB_DIV;
		end else begin
			PLL_PRESCALE_DIV <= prescale_div(cfg_q[CFG_PRESCALE_LSB +: 3]);
			SYS_BRANCH_DIV   <= SYS_BRANCH_BASE << cfg_q[CFG_SYSDIV_LSB +: 2];
			USB_BRANCH_DIV   <= USB_DIV;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n);

	chk_req_disabled: assert property (!sw_en |=> !req_q)
		else $error("switch request stayed set while switching disabled");
	chk_cur_initial: assert property (!sw_en
		|=> SYS_CLK_SRC == $past(cfg_q[CFG_INIT_SRC_LSB +: 3]))
		else $error("current source not following initial config");
	chk_redundant_abort: assert property (state_q == SW_COMPARE && new_src_q == cur_src_q && sw_en
		|=> state_q == SW_IDLE && !req_q)
		else $error("redundant switch not aborted");
	chk_start_clears: assert property (start_clr && !fail_s && !lock_s |=> !fail_q && !lock_q)
		else $error("lock or fail flag not cleared at switch start");
	chk_pll_wait: assert property (state_q == SW_START && src_pll(new_src_q) && !lock_s && sw_en
		|=> state_q == SW_START)
		else $error("left start state without PLL lock");
	chk_count_wait: assert property (state_q == SW_COUNT && !cnt_done |=> state_q != SW_SWAP)
		else $error("swap before ten new-source cycles");
	chk_swap_copy: assert property (state_q == SW_SWAP && sw_en
		|=> cur_src_q == $past(new_src_q) && !req_q)
		else $error("swap did not copy source or clear request");
	chk_keep_slow_rc: assert property (wdog_en |=> OSC_ENABLE[OSC_SLOW_RC])
		else $error("low-power RC stopped while watchdog enabled");
	chk_pll_pair: assert property (state_q == SW_COMPARE && bad_pair |=> state_q == SW_IDLE)
		else $error("direct PLL to PLL switch started");
	chk_bus_answer: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus answer delayed beyond one wait state");
	chk_usb_pll: assert property (usb_en |=> PLL_ENABLE && OSC_ENABLE[OSC_PRI])
		else $error("PLL off while USB enabled");
	chk_sys_div: assert property (cfg_q[CFG_SYSDIV_LSB +: 2] == 2'b11 ##1 $stable(cfg_q)
		|-> SYS_BRANCH_DIV == 5'h18)
		else $error("system branch divider wrong");
	chk_unlock_need: assert property (wr_hi && ulk_hi_q != ULK_OPEN |=> $stable(new_src_q))
		else $error("new source written without unlock");

	cov_full_switch: cover property (state_q == SW_COUNT ##[1:200] state_q == SW_SWAP);
	cov_redundant:   cover property (state_q == SW_COMPARE && new_src_q == cur_src_q);
	cov_pll_switch:  cover property (state_q == SW_START && src_pll(new_src_q) ##1 state_q == SW_COUNT);
	cov_bad_key:     cover property (ulk_lo_q == ULK_KEY1 && wr_lo && AVS_WRITEDATA[7:0] != KEY_LO_2);

endmodule : clock_switch_and_usb_pll

// file: clock_switch_and_usb_pll_tb.sv
`timescale 1ns/10ps
module clock_switch_and_usb_pll_tb;
	import clksw_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// design ports
	logic        CLK_SYS;
	logic        RESETN;
	logic [3:0]  AVS_ADDRESS;
	logic        AVS_READ;
	logic        AVS_WRITE;
	logic [3:0]  AVS_BYTEENABLE;
	logic [31:0] AVS_WRITEDATA;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic [3:0]  OSC_CLK_IN;
	logic        STARTUP_DONE;
	logic        PLL_LOCKED;
	logic        CLK_FAIL;
	logic [3:0]  OSC_ENABLE;
	logic        PLL_ENABLE;
	logic [2:0]  SYS_CLK_SRC;
	logic        SWITCH_BUSY;
	logic [3:0]  PLL_PRESCALE_DIV;
	logic [4:0]  SYS_BRANCH_DIV;
	logic [1:0]  USB_BRANCH_DIV;
	// bench state
	int          n_fail;
	int          n_compared;
	int          cyc;
	logic [1:0]  ocnt;
	logic [31:0] rd;

	clock_switch_and_usb_pll clock_switch_and_usb_pll_inst (
		.CLK_SYS(CLK_SYS), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.OSC_CLK_IN(OSC_CLK_IN), .STARTUP_DONE(STARTUP_DONE), .PLL_LOCKED(PLL_LOCKED),
		.CLK_FAIL(CLK_FAIL), .OSC_ENABLE(OSC_ENABLE), .PLL_ENABLE(PLL_ENABLE),
		.SYS_CLK_SRC(SYS_CLK_SRC), .SWITCH_BUSY(SWITCH_BUSY),
		.PLL_PRESCALE_DIV(PLL_PRESCALE_DIV), .SYS_BRANCH_DIV(SYS_BRANCH_DIV),
		.USB_BRANCH_DIV(USB_BRANCH_DIV)
	);

	////////////////////////////////////////////////////////////////////////////////
	// 10 mhz clock
	initial begin
		CLK_SYS = 1'b0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end

	// oscillators at a quarter of the system rate; hang guard
	assign OSC_CLK_IN = {4{ocnt[1]}};
	always @(posedge CLK_SYS) begin
		ocnt <= ocnt + 2'h1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, verdict and bus tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			n_fail++;
		end
	endtask : check

	task print_verdict;
		$display("comparisons %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	// one access held until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge CLK_SYS);
		AVS_ADDRESS <= a;
		AVS_BYTEENABLE <= be;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do begin
			@(posedge CLK_SYS);
			w++;
		end while (AVS_WAITREQUEST !== 1'b0 && w < 50);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		check(32'(w), 32'h2);
	endtask : bus

	// high byte unlock pair, then the new source
	task key_hi(input logic [2:0] src);
		bus(1'b1, OSC_CTRL_OFS, 4'h2, {16'h0, KEY_HI_1, 8'h0});
		bus(1'b1, OSC_CTRL_OFS, 4'h2, {16'h0, KEY_HI_2, 8'h0});
		bus(1'b1, OSC_CTRL_OFS, 4'h2, {16'h0, 5'h0, src, 8'h0});
	endtask : key_hi

	// low byte unlock pair, then the switch request
	task key_lo;
		bus(1'b1, OSC_CTRL_OFS, 4'h1, {24'h0, KEY_LO_1});
		bus(1'b1, OSC_CTRL_OFS, 4'h1, {24'h0, KEY_LO_2});
		bus(1'b1, OSC_CTRL_OFS, 4'h1, 32'h9);
	endtask : key_lo

	// full switch; gated sources hold until start-up or lock is given
	task do_switch(input logic [2:0] src, input logic [2:0] old, input logic gated,
			input logic [3:0] en);
		int t;
		@(posedge CLK_SYS);
		STARTUP_DONE <= 1'b0;
		PLL_LOCKED <= 1'b0;
		key_hi(src);
		key_lo();
		repeat (gated ? 80 : 20) @(negedge CLK_SYS);
		check(32'(SYS_CLK_SRC), 32'(old));
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'({rd[14:12], rd[5], rd[3], rd[0]}), 32'({old, 3'b001}));
		STARTUP_DONE <= 1'b1;
		PLL_LOCKED <= 1'b1;
		t = 0;
		while (SWITCH_BUSY !== 1'b0 && t < 200) begin
			@(negedge CLK_SYS);
			t++;
		end
		repeat (2) @(negedge CLK_SYS);
		check(32'(SYS_CLK_SRC), 32'(src));
		check(32'(OSC_ENABLE), 32'(en));
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'({rd[14:12], rd[0]}), 32'({src, 1'b0}));
		$display("test switch to %0d done", src);
	endtask : do_switch

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		RESETN = 1'b0;
		AVS_ADDRESS = 4'h0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_BYTEENABLE = 4'h0;
		AVS_WRITEDATA = 32'h0;
		STARTUP_DONE = 1'b0;
		PLL_LOCKED = 1'b0;
		CLK_FAIL = 1'b0;
		ocnt = 2'h0;
		cyc = 0;
		n_fail = 0;
		n_compared = 0;
		repeat (16) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		repeat (3) @(negedge CLK_SYS);
		check(32'(OSC_ENABLE), 32'h1);
		check(32'({PLL_ENABLE, SYS_CLK_SRC, SWITCH_BUSY}), 32'h0);
		check(32'({PLL_PRESCALE_DIV, SYS_BRANCH_DIV, USB_BRANCH_DIV}), 32'h008e);
		bus(1'b0, CFG_OFS, 4'hf, 32'h0);
		check(rd, 32'h1003);
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(rd, 32'h0);
		$display("test reset done");

		// switching disabled by default
		key_hi(SRC_SEC);
		key_lo();
		repeat (60) @(negedge CLK_SYS);
		check(32'({SYS_CLK_SRC, SWITCH_BUSY}), 32'h0);
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'({rd[14:12], rd[0]}), 32'h0);
		$display("test disabled done");

		// every prescaler and system divider code
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, CFG_OFS, 4'h3, 32'h1000 | (i << 5) | ((i % 4) << 8));
			repeat (2) @(negedge CLK_SYS);
			check(32'(PLL_PRESCALE_DIV), (i < 6) ? i + 1 : ((i == 6) ? 8 : 12));
			check(32'(SYS_BRANCH_DIV), 3 << (i % 4));
			check(32'(USB_BRANCH_DIV), 32'h2);
		end
		bus(1'b1, CFG_OFS, 4'h3, 32'h1000);
		$display("test dividers done");

		// redundant request aborts
		key_hi(SRC_FAST_RC);
		key_lo();
		repeat (5) @(negedge CLK_SYS);
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'({rd[14:12], rd[0], SWITCH_BUSY}), 32'h0);
		$display("test redundant done");

		// raise the fail flag, then walk through the sources
		@(posedge CLK_SYS);
		CLK_FAIL <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		CLK_FAIL <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'(rd[3]), 32'h1);
		do_switch(SRC_PRI, SRC_FAST_RC, 1'b1, 4'ha);
		do_switch(SRC_SEC, SRC_PRI, 1'b0, 4'hc);
		do_switch(SRC_FAST_RC, SRC_SEC, 1'b0, 4'h9);
		do_switch(SRC_FAST_RC_PLL, SRC_FAST_RC, 1'b1, 4'h9);
		check(32'({PLL_ENABLE, rd[5]}), 32'h3);

		// direct pll to pll switch refused
		key_hi(SRC_PRI_PLL);
		key_lo();
		repeat (5) @(negedge CLK_SYS);
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'({rd[14:12], rd[0], SWITCH_BUSY}), 32'({SRC_FAST_RC_PLL, 2'b00}));
		$display("test pll to pll done");

		// broken key: the source write must be ignored
		bus(1'b1, OSC_CTRL_OFS, 4'h2, {16'h0, KEY_HI_1, 8'h0});
		bus(1'b1, OSC_CTRL_OFS, 4'h2, 32'h5500);
		bus(1'b1, OSC_CTRL_OFS, 4'h2, {16'h0, KEY_HI_2, 8'h0});
		bus(1'b1, OSC_CTRL_OFS, 4'h2, 32'h0200);
		bus(1'b0, OSC_CTRL_OFS, 4'hf, 32'h0);
		check(32'(rd[10:8]), 32'(SRC_PRI_PLL));
		$display("test broken key done");

		// unmapped place reads zero and ignores writes
		bus(1'b1, 4'h8, 4'hf, 32'hffff);
		bus(1'b0, 4'h8, 4'hf, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, CFG_OFS, 4'hf, 32'h0);
		check(rd, 32'h1000);

		// usb and watchdog on, switching off: primary, pll and slow rc stay powered
		bus(1'b1, CFG_OFS, 4'h3, 32'h1c03);
		repeat (4) @(negedge CLK_SYS);
		check(32'({PLL_ENABLE, OSC_ENABLE}), 32'h1b);
		$display("test usb done");
		print_verdict();
	end

endmodule : clock_switch_and_usb_pll_tb

// file: new_clk_counter.sv
`timescale 1ns/10ps
module new_clk_counter (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       start,
	input  wire logic [1:0] sel,
	input  wire logic [3:0] osc_clk,
	// status
	output logic            done
);
	import clksw_pkg::*;

	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [3:0] last_q;
	logic [3:0] cnt_q;
	logic       edge_w;

	////////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for the raw oscillator clocks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
			last_q <= 4'h0;
		end else begin
			meta_q <= osc_clk;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// rising edge of the selected source
	assign edge_w = sync_q[sel] & ~last_q[sel];

	// count edges of the new source after start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
		end else if (start) begin
			cnt_q <= 4'h0;
		end else if (edge_w && cnt_q != NEW_SRC_WAIT) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	assign done = (cnt_q == NEW_SRC_WAIT) & ~start;

endmodule : new_clk_counter
